// ---- rtl/msi_pkg.sv ----
// How it works
// R1: level select set makes both interrupt pins active low, clear makes them active high.
// R2: drive select set makes interrupt pins open drain, clear makes them push-pull.
// R3: latch set holds pin until status clears; clear gives 50 us pulses.
// R4: any-read-clears set lets any register read clear status; else status read only.
// R5: frame-sync polarity set makes the frame-sync input active low, clear active high.
// R6: frame-sync enable lets a transition to the active level raise an interrupt.
// R7: routing clear puts everything on primary pin; set moves all but data ready.
// R8: motion-wake enable field 111 enables the motion-wake interrupt, 000 disables it.
// R9: overrun enable lets a buffer overflow raise an interrupt.
// R10: enable register bit 2 enables the gyro drive ready interrupt.
// R11: enable register bit 0 enables the data ready interrupt.
// R12: motion-wake status field reads 111 after the event, clears on status read.
// R13: overrun flag sets on buffer overflow, clears after the status register is read.
// R14: data ready flag sets on data ready, clears after the status register is read.
// R15: accel axes read as high then low byte, x, y, z, from x high.
// R16: temperature reads as high byte then low byte at consecutive addresses.
// R17: frame-sync flag sets on frame-sync interrupt, clears after its register is read.
// R18: with latch set, a pin asserts while any enabled event routed to it is pending.
// R19: reserved bits of config, enable and status read zero and ignore writes.
package msi_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [6:0] OFS_FRAME_SYNC_FLAGS = 7'h36;
  localparam logic [6:0] OFS_PIN_CONFIG = 7'h37;
  localparam logic [6:0] OFS_ENABLE_MASK = 7'h38;
  localparam logic [6:0] OFS_EVENT_FLAGS = 7'h3A;
  localparam logic [6:0] OFS_ACCEL_X_HIGH = 7'h3B;
  localparam logic [6:0] OFS_ACCEL_X_LOW = 7'h3C;
  localparam logic [6:0] OFS_ACCEL_Y_HIGH = 7'h3D;
  localparam logic [6:0] OFS_ACCEL_Y_LOW = 7'h3E;
  localparam logic [6:0] OFS_ACCEL_Z_HIGH = 7'h3F;
  localparam logic [6:0] OFS_ACCEL_Z_LOW = 7'h40;
  localparam logic [6:0] OFS_TEMP_HIGH = 7'h41;
  localparam logic [6:0] OFS_TEMP_LOW = 7'h42;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_ACTIVE_LOW_BIT = 7;
  localparam int CFG_OPEN_DRAIN_BIT = 6;
  localparam int CFG_LATCH_BIT = 5;
  localparam int CFG_ANY_READ_CLEAR_BIT = 4;
  localparam int CFG_FRAME_SYNC_POLARITY_BIT = 3;
  localparam int CFG_FRAME_SYNC_IRQ_ENABLE_BIT = 2;
  localparam int CFG_SECOND_PIN_ROUTING_BIT = 0;
  localparam int EN_MOTION_WAKE_LSB = 5;
  localparam int EN_BUFFER_OVERRUN_BIT = 4;
  localparam int EN_GYRO_DRIVE_READY_BIT = 2;
  localparam int EN_DATA_READY_BIT = 0;
  localparam int FRAME_SYNC_FLAG_BIT = 7;

  // ----------------------------------------
  // masks, codes and reset values
  // ----------------------------------------
  localparam logic [7:0] PIN_CONFIG_MASK = 8'hFD;
  localparam logic [7:0] ENABLE_MASK_BITS = 8'hF5;
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
  localparam logic [7:0] ENABLE_MASK_RESET = 8'h00;
  localparam logic [2:0] MOTION_WAKE_ALL = 3'h7;
  localparam logic [2:0] MOTION_WAKE_NONE = 3'h0;
  localparam int NUM_SOURCES = 5;
  localparam logic [4:0] SRC_DATA_READY_MASK = 5'h01;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int IRQ_PULSE_NS = 50000;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic [15:0] temperature;
  } msi_sample_t;

  typedef struct packed {
    logic motion_wake;
    logic buffer_overrun;
    logic gyro_drive_ready;
    logic data_ready;
  } msi_events_t;

endpackage

// ---- rtl/msi_sync.sv ----
`timescale 1ns/1ns
module msi_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_q;
  logic sync_q;

  // ----------------------------------------
  // two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ---- rtl/msi_irq_pin.sv ----
`timescale 1ns/1ns
module msi_irq_pin #(
  parameter int PULSE_CYC = msi_pkg::IRQ_PULSE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pending_i,
  input wire logic trigger_i,
  input wire logic latch_en_i,
  input wire logic active_low_i,
  input wire logic open_drain_i,
  output logic pin_o,
  output logic pin_oe_o
);

  localparam int CW = $clog2(PULSE_CYC + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic pin_q, pin_d;
  logic oe_q, oe_d;
  logic active;
  logic level;
  logic [CW-1:0] run_q, run_d;

  // ----------------------------------------
  // pulse timer and pin drive
  // ----------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (busy_q) begin
      if (cnt_q == CW'(PULSE_CYC - 1)) begin
        busy_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end else if (trigger_i && !latch_en_i) begin
      busy_d = 1'b1; // R3
      cnt_d = '0;
    end
    active = latch_en_i ? pending_i : busy_d; // R3
    level = active ^ active_low_i; // R1
    if (open_drain_i) begin
      pin_d = 1'b0; // R2
      oe_d = ~level;
    end else begin
      pin_d = level;
      oe_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------
  // pulse length monitor for the checks
  // ----------------------------------------
  always_comb begin
    run_d = busy_q ? run_q + CW'(1) : '0;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_q <= '0;
    end else begin
      run_q <= run_d;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  pulse_width_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R3
    $fell(busy_q) |-> (run_q == CW'(PULSE_CYC)))
    else $error("pulse width not the configured length");

  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R18
    (latch_en_i && pending_i && !open_drain_i) |=> (pin_o == !$past(active_low_i)))
    else $error("latched pin not asserted while pending");

  drain_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R2
    $past(open_drain_i) |-> (!pin_o && (pin_oe_o == !$past(level))))
    else $error("open drain pin drove high");

endmodule

// ---- rtl/msi_irq_ctrl.sv ----
`timescale 1ns/1ns
module msi_irq_ctrl #(
  parameter int PULSE_CYC = msi_pkg::IRQ_PULSE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire msi_pkg::msi_events_t events_i,
  input wire msi_pkg::msi_sample_t sample_i,
  input wire logic frame_sync_input_i,
  output logic irq_pin_o,
  output logic irq_pin_oe_o,
  output logic second_irq_pin_o,
  output logic second_irq_pin_oe_o
);

  localparam int NS = msi_pkg::NUM_SOURCES;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] en_q, en_d;
  logic [2:0] wake_flag_q, wake_flag_d;
  logic overrun_flag_q, overrun_flag_d;
  logic gyro_flag_q, gyro_flag_d;
  logic drdy_flag_q, drdy_flag_d;
  logic fs_flag_q, fs_flag_d;
  logic fs_prev_q, fs_prev_d;
  logic [7:0] rdata_q, rdata_d;

  logic fs_sync;
  logic fs_lvl;
  logic fs_prev_lvl;
  logic fs_event;
  logic clr_status;
  logic clr_fs;
  logic [NS-1:0] src_set;
  logic [NS-1:0] src_pend;
  logic [NS-1:0] src_en;
  logic [NS-1:0] route_second;
  logic [NS-1:0] route_pri;
  logic pend_pri;
  logic pend_second;
  logic trig_pri;
  logic trig_second;
  logic wake_enabled;

  // ----------------------------------------
  // frame-sync input
  // ----------------------------------------
  msi_sync u_fs_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(frame_sync_input_i),
    .sync_o(fs_sync)
  );

  always_comb begin
    fs_prev_d = fs_sync;
    fs_lvl = cfg_q[msi_pkg::CFG_FRAME_SYNC_POLARITY_BIT] ? ~fs_sync : fs_sync; // R5
    fs_prev_lvl = cfg_q[msi_pkg::CFG_FRAME_SYNC_POLARITY_BIT] ? ~fs_prev_q : fs_prev_q; // R5
    fs_event = cfg_q[msi_pkg::CFG_FRAME_SYNC_IRQ_ENABLE_BIT] && fs_lvl && !fs_prev_lvl; // R6
  end

  // ----------------------------------------
  // configuration and enable registers
  // ----------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    en_d = en_q;
    if (reg_wr_i && reg_addr_i == msi_pkg::OFS_PIN_CONFIG) begin
      cfg_d = reg_wdata_i & msi_pkg::PIN_CONFIG_MASK; // R19
    end
    if (reg_wr_i && reg_addr_i == msi_pkg::OFS_ENABLE_MASK) begin
      en_d = reg_wdata_i & msi_pkg::ENABLE_MASK_BITS; // R19
    end
  end

  // ----------------------------------------
  // event flags, set wins over clear
  // ----------------------------------------
  always_comb begin
    clr_status = reg_rd_i && (reg_addr_i == msi_pkg::OFS_EVENT_FLAGS ||
                              cfg_q[msi_pkg::CFG_ANY_READ_CLEAR_BIT]); // R4
    clr_fs = reg_rd_i && (reg_addr_i == msi_pkg::OFS_FRAME_SYNC_FLAGS ||
                          cfg_q[msi_pkg::CFG_ANY_READ_CLEAR_BIT]); // R4
    wake_flag_d = wake_flag_q;
    overrun_flag_d = overrun_flag_q;
    gyro_flag_d = gyro_flag_q;
    drdy_flag_d = drdy_flag_q;
    fs_flag_d = fs_flag_q;
    if (events_i.motion_wake) begin
      wake_flag_d = msi_pkg::MOTION_WAKE_ALL; // R12
    end else if (clr_status) begin
      wake_flag_d = msi_pkg::MOTION_WAKE_NONE; // R12
    end
    if (events_i.buffer_overrun) begin
      overrun_flag_d = 1'b1; // R13
    end else if (clr_status) begin
      overrun_flag_d = 1'b0; // R13
    end
    if (events_i.gyro_drive_ready) begin
      gyro_flag_d = 1'b1;
    end else if (clr_status) begin
      gyro_flag_d = 1'b0;
    end
    if (events_i.data_ready) begin
      drdy_flag_d = 1'b1; // R14
    end else if (clr_status) begin
      drdy_flag_d = 1'b0; // R14
    end
    if (fs_event) begin
      fs_flag_d = 1'b1; // R17
    end else if (clr_fs) begin
      fs_flag_d = 1'b0; // R17
    end
  end

  // ----------------------------------------
  // routing and pin requests
  // ----------------------------------------
  always_comb begin
    wake_enabled = en_q[msi_pkg::EN_MOTION_WAKE_LSB +: 3] == msi_pkg::MOTION_WAKE_ALL; // R8
    src_en = {cfg_q[msi_pkg::CFG_FRAME_SYNC_IRQ_ENABLE_BIT], // R6
              wake_enabled,
              en_q[msi_pkg::EN_BUFFER_OVERRUN_BIT], // R9
              en_q[msi_pkg::EN_GYRO_DRIVE_READY_BIT], // R10
              en_q[msi_pkg::EN_DATA_READY_BIT]}; // R11
    src_set = {fs_event, events_i.motion_wake, events_i.buffer_overrun,
               events_i.gyro_drive_ready, events_i.data_ready};
    src_pend = {fs_flag_q, wake_flag_q == msi_pkg::MOTION_WAKE_ALL, overrun_flag_q,
                gyro_flag_q, drdy_flag_q};
    route_second = cfg_q[msi_pkg::CFG_SECOND_PIN_ROUTING_BIT] ?
                   ~msi_pkg::SRC_DATA_READY_MASK : '0; // R7
    route_pri = ~route_second; // R7
    pend_pri = |(src_pend & src_en & route_pri); // R18
    pend_second = |(src_pend & src_en & route_second); // R18
    trig_pri = |(src_set & src_en & route_pri);
    trig_second = |(src_set & src_en & route_second);
  end

  msi_irq_pin #(
    .PULSE_CYC(PULSE_CYC)
  ) u_pin_pri (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pending_i(pend_pri),
    .trigger_i(trig_pri),
    .latch_en_i(cfg_q[msi_pkg::CFG_LATCH_BIT]),
    .active_low_i(cfg_q[msi_pkg::CFG_ACTIVE_LOW_BIT]),
    .open_drain_i(cfg_q[msi_pkg::CFG_OPEN_DRAIN_BIT]),
    .pin_o(irq_pin_o),
    .pin_oe_o(irq_pin_oe_o)
  );

  msi_irq_pin #(
    .PULSE_CYC(PULSE_CYC)
  ) u_pin_second (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pending_i(pend_second),
    .trigger_i(trig_second),
    .latch_en_i(cfg_q[msi_pkg::CFG_LATCH_BIT]),
    .active_low_i(cfg_q[msi_pkg::CFG_ACTIVE_LOW_BIT]),
    .open_drain_i(cfg_q[msi_pkg::CFG_OPEN_DRAIN_BIT]),
    .pin_o(second_irq_pin_o),
    .pin_oe_o(second_irq_pin_oe_o)
  );

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        msi_pkg::OFS_FRAME_SYNC_FLAGS: rdata_d = {fs_flag_q, 7'h00}; // R17
        msi_pkg::OFS_PIN_CONFIG: rdata_d = cfg_q;
        msi_pkg::OFS_ENABLE_MASK: rdata_d = en_q;
        msi_pkg::OFS_EVENT_FLAGS: rdata_d = {wake_flag_q, overrun_flag_q, 1'b0, gyro_flag_q, 1'b0,
                                             drdy_flag_q}; // R19
        msi_pkg::OFS_ACCEL_X_HIGH: rdata_d = sample_i.accel_x[15:8]; // R15
        msi_pkg::OFS_ACCEL_X_LOW: rdata_d = sample_i.accel_x[7:0]; // R15
        msi_pkg::OFS_ACCEL_Y_HIGH: rdata_d = sample_i.accel_y[15:8]; // R15
        msi_pkg::OFS_ACCEL_Y_LOW: rdata_d = sample_i.accel_y[7:0]; // R15
        msi_pkg::OFS_ACCEL_Z_HIGH: rdata_d = sample_i.accel_z[15:8]; // R15
        msi_pkg::OFS_ACCEL_Z_LOW: rdata_d = sample_i.accel_z[7:0]; // R15
        msi_pkg::OFS_TEMP_HIGH: rdata_d = sample_i.temperature[15:8]; // R16
        msi_pkg::OFS_TEMP_LOW: rdata_d = sample_i.temperature[7:0]; // R16
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q <= msi_pkg::PIN_CONFIG_RESET;
      en_q <= msi_pkg::ENABLE_MASK_RESET;
      wake_flag_q <= msi_pkg::MOTION_WAKE_NONE;
      overrun_flag_q <= 1'b0;
      gyro_flag_q <= 1'b0;
      drdy_flag_q <= 1'b0;
      fs_flag_q <= 1'b0;
      fs_prev_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      en_q <= en_d;
      wake_flag_q <= wake_flag_d;
      overrun_flag_q <= overrun_flag_d;
      gyro_flag_q <= gyro_flag_d;
      drdy_flag_q <= drdy_flag_d;
      fs_flag_q <= fs_flag_d;
      fs_prev_q <= fs_prev_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cfg_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R19
    (reg_wr_i && reg_addr_i == msi_pkg::OFS_PIN_CONFIG) |=> (cfg_q == ($past(reg_wdata_i) & 8'hFD)))
    else $error("config write not stored with reserved bit zero");

  status_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R13
    (reg_rd_i && reg_addr_i == msi_pkg::OFS_EVENT_FLAGS && !events_i.buffer_overrun)
    |=> !overrun_flag_q)
    else $error("overrun flag survived status read");

  set_wins_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R14
    (events_i.data_ready && clr_status) |=> drdy_flag_q ##1 (drdy_flag_q || $past(clr_status)))
    else $error("data ready lost in clear cycle");

  wake_status_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
    events_i.motion_wake |=> (wake_flag_q == msi_pkg::MOTION_WAKE_ALL))
    else $error("motion wake field not all ones");

  fs_blocked_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R6
    (!cfg_q[2] && !fs_flag_q) |=> !fs_flag_q)
    else $error("disabled frame sync raised a flag");

  route_split_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R7
    cfg_q[0] |-> (pend_pri == (drdy_flag_q && en_q[0])))
    else $error("primary pin carries more than data ready");

  route_single_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R7
    !cfg_q[0] |-> (!pend_second && !trig_second))
    else $error("second pin used while routing clear");

  any_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R4
    (reg_rd_i && cfg_q[4] && !fs_event) |=> !fs_flag_q)
    else $error("any read did not clear frame sync flag");

  enable_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R19
    (reg_wr_i && reg_addr_i == msi_pkg::OFS_ENABLE_MASK) |=> (en_q == ($past(reg_wdata_i) & 8'hF5)))
    else $error("enable write not stored with reserved bits zero");

  status_reserved_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R19
    (reg_rd_i && reg_addr_i == msi_pkg::OFS_EVENT_FLAGS) |=> ((reg_rdata_o & 8'h0A) == 8'h00))
    else $error("reserved status bits read as one");

  fs_reserved_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R19
    (reg_rd_i && reg_addr_i == msi_pkg::OFS_FRAME_SYNC_FLAGS) |=> (reg_rdata_o[6:0] == 7'h00))
    else $error("reserved frame sync bits read as one");

  accel_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R15
    (reg_rd_i && reg_addr_i == msi_pkg::OFS_ACCEL_X_HIGH) |=>
    (reg_rdata_o == $past(sample_i.accel_x[15:8])))
    else $error("accel x high byte read wrong");

  temp_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R16
    (reg_rd_i && reg_addr_i == msi_pkg::OFS_TEMP_LOW) |=>
    (reg_rdata_o == $past(sample_i.temperature[7:0])))
    else $error("temperature low byte read wrong");

  overrun_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R13
    events_i.buffer_overrun |=> overrun_flag_q)
    else $error("overrun flag not set by overflow");

  drdy_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R14
    events_i.data_ready |=> drdy_flag_q)
    else $error("data ready flag not set by event");

  fs_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R17
    fs_event |=> fs_flag_q)
    else $error("frame sync flag not set by event");

  fs_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R17
    (reg_rd_i && reg_addr_i == msi_pkg::OFS_FRAME_SYNC_FLAGS && !fs_event) |=> !fs_flag_q)
    else $error("frame sync flag survived its read");

  fs_edge_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R5
    fs_event |-> (fs_sync != fs_prev_q && fs_sync != cfg_q[msi_pkg::CFG_FRAME_SYNC_POLARITY_BIT]))
    else $error("frame sync event on wrong level");

  masked_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R9
    (en_q[7:5] != 3'h7 && !en_q[4] && !en_q[2] && !en_q[0] && !cfg_q[2]) |->
    !(pend_pri || pend_second || trig_pri || trig_second))
    else $error("disabled source requested a pin");

endmodule

// ---- sim/msi_host_model.sv ----
`timescale 1ns/1ns
module msi_host_model (
  input wire logic core_clk_i,
  output logic [6:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic irq_pin_i,
  input wire logic irq_pin_oe_i,
  input wire logic second_irq_pin_i,
  input wire logic second_irq_pin_oe_i,
  output logic irq_wire_o,
  output logic second_wire_o
);
  // ----------------------------------------
  // pin wires, released pins pulled up
  // ----------------------------------------
  assign irq_wire_o = irq_pin_oe_i ? irq_pin_i : 1'b1;
  assign second_wire_o = second_irq_pin_oe_i ? second_irq_pin_i : 1'b1;

  // ----------------------------------------
  // register port cycles
  // ----------------------------------------
  initial begin
    reg_addr_o = 7'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
endmodule

// ---- sim/tb_msi_irq_ctrl.sv ----
`timescale 1ns/1ns
module tb_msi_irq_ctrl;
  localparam int PC = 20;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  msi_pkg::msi_events_t events_i = '0;
  msi_pkg::msi_sample_t sample_i = '0;
  logic fs_in = 1'b0;
  logic irq_pin;
  logic irq_oe;
  logic sec_pin;
  logic sec_oe;
  logic irq_wire;
  logic sec_wire;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] d;
  logic [31:0] r;

  always #50 core_clk_i = ~core_clk_i;

  msi_host_model host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
    .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .irq_pin_i(irq_pin),
    .irq_pin_oe_i(irq_oe), .second_irq_pin_i(sec_pin), .second_irq_pin_oe_i(sec_oe),
    .irq_wire_o(irq_wire), .second_wire_o(sec_wire));

  msi_irq_ctrl #(.PULSE_CYC(PC)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
    .reg_rd_i(reg_rd), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .events_i(events_i), .sample_i(sample_i), .frame_sync_input_i(fs_in), .irq_pin_o(irq_pin),
    .irq_pin_oe_o(irq_oe), .second_irq_pin_o(sec_pin), .second_irq_pin_oe_o(sec_oe));

  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [7:0] exp_status(input logic [3:0] e);
    return {{3{e[3]}}, e[2], 1'b0, e[1], 1'b0, e[0]};
  endfunction

  function automatic logic [7:0] exp_sample(input msi_pkg::msi_sample_t s, input logic [6:0] a);
    logic [63:0] v;
    int k;
    v = s;
    k = a - 7'h3B;
    return v[63 - 8 * k -: 8];
  endfunction

  task automatic stop_test;
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk_byte(d, e);
  endtask

  task automatic cfg(input logic [7:0] c, input logic [7:0] e);
    host.wr(7'h37, c);
    host.wr(7'h38, e);
    @(negedge core_clk_i);
  endtask

  task automatic pulse(input logic [3:0] e);
    @(negedge core_clk_i);
    events_i = e;
    @(negedge core_clk_i);
    events_i = '0;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    r = $urandom(27);
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk_pin(irq_wire, 1'b0);
    rd_chk(7'h37, 8'h00);
    rd_chk(7'h38, 8'h00);
    rd_chk(7'h3A, 8'h00);
    rd_chk(7'h10, 8'h00);
    host.wr(7'h37, 8'hFF);
    rd_chk(7'h37, 8'hFD);
    host.wr(7'h38, 8'hFF);
    rd_chk(7'h38, 8'hF5);
    for (int i = 0; i < 40; i++) begin
      r = $urandom();
      sample_i = {$urandom(), $urandom()};
      host.wr(7'h3B + r[2:0], r[15:8]);
      rd_chk(7'h3B + r[2:0], exp_sample(sample_i, 7'h3B + r[2:0]));
      pulse(r[7:4]);
      rd_chk(7'h3A, exp_status(r[7:4]));
    end
    host.wr(7'h37, 8'h00);
    host.rd(7'h36, d);
    for (int rt = 0; rt < 2; rt++) begin
      cfg(8'h20 | 8'(rt), 8'hF5);
      for (int i = 0; i < 4; i++) begin
        pulse(4'h1 << i);
        @(negedge core_clk_i);
        chk_pin(irq_wire, rt == 0 || i == 0);
        chk_pin(sec_wire, rt == 1 && i != 0);
        rd_chk(7'h3A, exp_status(4'h1 << i));
        @(negedge core_clk_i);
        chk_pin(irq_wire | sec_wire, 1'b0);
      end
    end
    cfg(8'h20, 8'h20);
    pulse(4'hF);
    @(negedge core_clk_i);
    chk_pin(irq_wire, 1'b0);
    rd_chk(7'h3A, 8'hF5);
    cfg(8'hE0, 8'h01);
    chk_pin(irq_oe, 1'b0);
    chk_pin(irq_wire, 1'b1);
    pulse(4'h1);
    @(negedge core_clk_i);
    chk_pin(irq_oe, 1'b1);
    chk_pin(irq_wire, 1'b0);
    rd_chk(7'h3A, 8'h01);
    cfg(8'hA0, 8'h01);
    chk_pin(irq_oe, 1'b1);
    chk_pin(irq_wire, 1'b1);
    cfg(8'h00, 8'h01);
    pulse(4'h1);
    n = 0;
    while (irq_wire === 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk_i);
    end
    chk_byte(8'(n), 8'(PC));
    rd_chk(7'h3A, 8'h01);
    cfg(8'h30, 8'h01);
    pulse(4'h1);
    host.rd(7'h3B, d);
    rd_chk(7'h3A, 8'h00);
    cfg(8'h20, 8'h01);
    pulse(4'h1);
    host.rd(7'h3B, d);
    rd_chk(7'h3A, 8'h01);
    fork
      host.rd(7'h3A, d);
      pulse(4'h1);
    join
    chk_byte(d, 8'h00);
    rd_chk(7'h3A, 8'h01);
    cfg(8'h24, 8'h00);
    host.rd(7'h36, d);
    fs_in = 1'b1;
    repeat (6) @(negedge core_clk_i);
    rd_chk(7'h36, 8'h80);
    rd_chk(7'h36, 8'h00);
    cfg(8'h2C, 8'h00);
    host.rd(7'h36, d);
    fs_in = 1'b0;
    repeat (6) @(negedge core_clk_i);
    rd_chk(7'h36, 8'h80);
    cfg(8'h28, 8'h00);
    fs_in = 1'b1;
    repeat (6) @(negedge core_clk_i);
    fs_in = 1'b0;
    repeat (6) @(negedge core_clk_i);
    rd_chk(7'h36, 8'h00);
    stop_test();
  end
endmodule
